// file: rtl/aes_engine_regs.vh
// Address map, field positions, reset values and timing of the AES engine
`ifndef AES_ENGINE_REGS_VH
`define AES_ENGINE_REGS_VH

`define AES_ADDR_STATUS    8'h82
`define AES_ADDR_CTRL      8'h83
`define AES_ADDR_WIN_LO    8'h84
`define AES_ADDR_WIN_HI    8'h93
`define AES_ADDR_ALIAS     8'h94

`define AES_CTRL_REQ       7
`define AES_CTRL_MODE      6:4
`define AES_CTRL_DIR       3
`define AES_STAT_ERR       7
`define AES_STAT_DONE      0

`define AES_MODE_ECB       3'h0
`define AES_MODE_KEY       3'h1
`define AES_MODE_CBC       3'h2
`define AES_MODE_RST       3'h0
`define AES_DIR_ENC        1'b0
`define AES_BYTE_RST       8'h00
`define AES_BLOCK_RST      128'h0
`define AES_MASK_RST       16'h0000
`define AES_MASK_FULL      16'hffff
`define AES_CLKDIV_OFF     3'h0

`define AES_ROUND_FIRST    4'h1
`define AES_ROUND_LAST     4'ha
`define AES_RCON_BASE      4'hb
`define AES_GF_POLY        8'h1b
`define AES_AFFINE_C       8'h63
`define AES_INV_AFFINE_C   8'h05

`define AES_CLK_PERIOD_NS  25
`define AES_RUN_MAX_NS     24000
`define AES_RUN_MAX_CYC    (`AES_RUN_MAX_NS / `AES_CLK_PERIOD_NS)

`endif

// file: rtl/aes_sbox.v
// One AES substitution byte, forward or inverse, from GF(2^8) inversion
`default_nettype none
`include "aes_engine_regs.vh"

module aes_sbox (
    // Byte in
    input  wire [7:0] din,
    input  wire       inverse,
    // Byte out
    output wire [7:0] dout
);
    function [7:0] gf_mul;
        input [7:0] a;
        input [7:0] b;
        reg   [7:0] p;
        reg   [7:0] x;
        integer     i;
        begin
            p = `AES_BYTE_RST;
            x = a;
            for (i = 0; i < 8; i = i + 1) begin
                if (b[i])
                    p = p ^ x;
                x = {x[6:0], 1'b0} ^ (x[7] ? `AES_GF_POLY : `AES_BYTE_RST);
            end
            gf_mul = p;
        end
    endfunction

    // x^254 is the inverse; zero maps to zero
    function [7:0] gf_inv;
        input [7:0] a;
        reg   [7:0] sq;
        reg   [7:0] acc;
        integer     k;
        begin
            sq  = a;
            acc = 8'h01;
            for (k = 1; k < 8; k = k + 1) begin
                sq  = gf_mul(sq, sq);
                acc = gf_mul(acc, sq);
            end
            gf_inv = acc;
        end
    endfunction

    function [7:0] rotl;
        input [7:0] x;
        input [2:0] n;
        reg   [15:0] d;
        begin
            d    = {x, x} << n;
            rotl = d[15:8];
        end
    endfunction

    wire [7:0] fwd_inv = gf_inv(din);
    wire [7:0] fwd     = fwd_inv ^ rotl(fwd_inv, 3'd1) ^ rotl(fwd_inv, 3'd2)
                         ^ rotl(fwd_inv, 3'd3) ^ rotl(fwd_inv, 3'd4) ^ `AES_AFFINE_C;
    wire [7:0] un_aff  = rotl(din, 3'd1) ^ rotl(din, 3'd3) ^ rotl(din, 3'd6)
                         ^ `AES_INV_AFFINE_C;

    assign dout = inverse ? gf_inv(un_aff) : fwd;
endmodule // aes_sbox

`default_nettype wire

// file: rtl/aes_round.v
// One AES round on a 128-bit state, encrypting or decrypting
`default_nettype none
`include "aes_engine_regs.vh"

module aes_round (
    // Round inputs
    input  wire [127:0] state_in,
    input  wire [127:0] round_key,
    input  wire         decrypt,
    input  wire         last_round,
    // Round result
    output wire [127:0] state_out
);
    function [7:0] gf_mul;
        input [7:0] a;
        input [7:0] b;
        reg   [7:0] p;
        reg   [7:0] x;
        integer     i;
        begin
            p = `AES_BYTE_RST;
            x = a;
            for (i = 0; i < 8; i = i + 1) begin
                if (b[i])
                    p = p ^ x;
                x = {x[6:0], 1'b0} ^ (x[7] ? `AES_GF_POLY : `AES_BYTE_RST);
            end
            gf_mul = p;
        end
    endfunction

    function [7:0] coef;
        input [1:0] k;
        input       inv;
        begin
            case (k)
                2'd0:    coef = inv ? 8'h0e : 8'h02;
                2'd1:    coef = inv ? 8'h0b : 8'h03;
                2'd2:    coef = inv ? 8'h0d : 8'h01;
                default: coef = inv ? 8'h09 : 8'h01;
            endcase
        end
    endfunction

    function [31:0] mix_col;
        input [31:0] col;
        input        inv;
        reg   [7:0]  acc;
        integer      i;
        integer      j;
        begin
            mix_col = 32'h0;
            for (i = 0; i < 4; i = i + 1) begin
                acc = `AES_BYTE_RST;
                for (j = 0; j < 4; j = j + 1)
                    acc = acc ^ gf_mul(col[31-8*j -: 8], coef(j[1:0] - i[1:0], inv));
                mix_col[31-8*i -: 8] = acc;
            end
        end
    endfunction

    wire [127:0] inv_shifted;
    wire [127:0] sub_out;
    wire [127:0] shifted;
    wire [127:0] add_key = sub_out ^ round_key;
    wire [127:0] mix_in  = decrypt ? add_key : shifted;
    wire [127:0] mixed;

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_byte
            localparam integer ROW = g % 4;
            localparam integer COL = g / 4;
            localparam integer FWD = ROW + 4 * ((COL + ROW) % 4);
            localparam integer INV = ROW + 4 * ((COL + 4 - ROW) % 4);
            assign inv_shifted[127-8*g -: 8] = state_in[127-8*INV -: 8];
            // Substitution commutes with row shifting, so one sbox set serves both ways
            aes_sbox u_sbox (
                .din     (decrypt ? inv_shifted[127-8*g -: 8] : state_in[127-8*g -: 8]),
                .inverse (decrypt),
                .dout    (sub_out[127-8*g -: 8])
            );
            assign shifted[127-8*g -: 8] = sub_out[127-8*FWD -: 8];
        end
        for (g = 0; g < 4; g = g + 1) begin : g_col
            assign mixed[127-32*g -: 32] = mix_col(mix_in[127-32*g -: 32], decrypt);
        end
    endgenerate

    assign state_out = decrypt ? (last_round ? add_key : mixed)
                               : ((last_round ? shifted : mixed) ^ round_key);
endmodule // aes_round

`default_nettype wire

// file: rtl/aes_engine.v
// AES-128 engine behind the host SRAM-style access window
// Summary of operation
// R1: Engine reachable only by SRAM-type byte accesses at addresses 0x82 to 0x94.
// R2: Host loads a key by setting mode 1, then writing 0x84 to 0x93.
// R3: Key and data share addresses; mode at access time picks the page.
// R4: Key page reads give the last round key of the previous run.
// R5: Loaded key kept apart, never changed by runs, reused for every run.
// R6: Mode 0 is single-block code book; direction bit picks encrypt or decrypt.
// R7: Writing request bit 1 at 0x83 or its alias 0x94 starts a run.
// R8: Host should write control, 16 data bytes and alias in one transfer.
// R9: Chained mode XORs previous result into new block, then encrypts.
// R10: Host runs the first chain block in code book mode, pre-XORed with IV.
// R11: Host keeps direction at encrypt for chained mode; no chained decryption.
// R12: Core runs well within 24 us per block.
// R13: Each written byte returns that location's old content, one byte later serially.
// R14: Host collects the last result with one extra dummy transfer.
// R15: Any data write overwrites the previous run's stored result.
// R16: Write-with-readback applies to every write in 0x82 to 0x94, no enable.
// R17: With radio off, engine works only while master clock divider is nonzero.
// R18: All host accesses are ignored while the transceiver sleeps.
// R19: Sleep or reset clears configuration, data and both keys.
// R20: Engine runs independently of the radio datapath.
// R21: Mode field bits 6:4 (0 book, 1 key, 2 chain), direction bit 3.
// R22: Status 0x82 bit 0 is done: low while running, high when finished.
// R23: Any access to control 0x83 during a run aborts it.
// R24: Status bit 7 flags control access during run or short result readback.
// R25: Old byte is captured for output before the new byte is stored.
`default_nettype none
`include "aes_engine_regs.vh"

module aes_engine (
    // Clock, reset, enable
    input  wire       ref_clk,
    input  wire       reset,
    input  wire       clk_en,
    // Transceiver state
    input  wire       radio_sleep,
    input  wire       radio_off_state,
    input  wire [2:0] master_clock_divider_select,
    // Host SRAM byte access
    input  wire       sram_valid,
    input  wire       sram_write,
    input  wire [7:0] sram_addr,
    input  wire [7:0] sram_wdata,
    input  wire       sram_end,
    // Read-back and status
    output reg  [7:0] sram_rdata,
    output reg        sram_rvalid,
    output reg        engine_busy,
    output reg        cipher_done_flag,
    output reg        cipher_error_flag
);
    // Configuration
    reg  [2:0]   mode;
    reg          dir;
    reg          run_dec;
    reg  [3:0]   rnd;

    // Pages and chaining store
    reg  [127:0] data_page;
    reg  [127:0] key_work;
    reg  [127:0] key_init;
    reg  [127:0] chain;
    reg  [15:0]  read_mask;

    function [7:0] byte_of;
        input [127:0] v;
        input [3:0]   i;
        begin
            byte_of = v[127-8*i -: 8];
        end
    endfunction

    function [127:0] put_byte;
        input [127:0] v;
        input [3:0]   i;
        input [7:0]   b;
        begin
            put_byte = v;
            put_byte[127-8*i -: 8] = b;
        end
    endfunction

    function [7:0] rcon;
        input [3:0] n;
        reg   [7:0] r;
        integer     k;
        begin
            r = 8'h01;
            for (k = 1; k < n; k = k + 1)
                r = {r[6:0], 1'b0} ^ (r[7] ? `AES_GF_POLY : `AES_BYTE_RST);
            rcon = r;
        end
    endfunction

    // Access qualification
    wire clock_missing = radio_off_state
                         && (master_clock_divider_select == `AES_CLKDIV_OFF); // R17
    wire engine_ok     = !radio_sleep && !clock_missing;                      // R18
    wire host_acc      = sram_valid && engine_ok;

    // Address decode, confined to 0x82..0x94
    wire [7:0] win_off  = sram_addr - `AES_ADDR_WIN_LO;
    wire [3:0] win_idx  = win_off[3:0];
    wire       is_stat  = (sram_addr == `AES_ADDR_STATUS);                    // R1
    wire       is_ctrl  = (sram_addr == `AES_ADDR_CTRL);
    wire       is_alias = (sram_addr == `AES_ADDR_ALIAS);
    wire       in_win   = (sram_addr >= `AES_ADDR_WIN_LO)
                          && (sram_addr <= `AES_ADDR_WIN_HI);
    wire       key_page = (mode == `AES_MODE_KEY);                            // R3

    // Control write decode
    wire [2:0] new_mode = sram_wdata[`AES_CTRL_MODE];                         // R21
    wire       new_dir  = sram_wdata[`AES_CTRL_DIR];
    wire       ctrl_wr  = host_acc && sram_write && (is_ctrl || is_alias);
    wire       runnable = (new_mode == `AES_MODE_ECB) || (new_mode == `AES_MODE_CBC);
    wire       abort    = host_acc && is_ctrl && engine_busy;                 // R23
    wire       start    = ctrl_wr && !engine_busy && runnable
                          && sram_wdata[`AES_CTRL_REQ];                       // R7
    wire       win_wr   = host_acc && sram_write && in_win && !engine_busy;

    // Chained mode folds the previous result into the new block
    wire [127:0] run_input = (new_mode == `AES_MODE_CBC) ? (data_page ^ chain)
                                                         : data_page;         // R9

    // Byte returned for this access; old content, before any store
    reg  [7:0] rd_byte;
    wire [7:0] status_byte = {cipher_error_flag, 6'b000000, cipher_done_flag};
    wire [7:0] ctrl_byte   = {1'b0, mode, dir, 3'b000};

    always @* begin
        rd_byte = `AES_BYTE_RST;
        if (is_stat)
            rd_byte = status_byte;                                            // R22
        else if (is_ctrl || is_alias)
            rd_byte = ctrl_byte;
        else if (in_win)
            rd_byte = key_page ? byte_of(key_work, win_idx)                   // R4
                               : byte_of(data_page, win_idx);
    end

    // Result readback tracking over one transfer
    wire        data_touch = host_acc && in_win && !key_page;
    wire [15:0] win_bit    = 16'h8000 >> win_idx;
    wire [15:0] mask_now   = data_touch ? (read_mask | win_bit) : read_mask;
    wire        short_read = (mask_now != `AES_MASK_RST) && (mask_now != `AES_MASK_FULL);

    // Key schedule: forward for encryption, backward from the final key for decryption
    wire [31:0] w0 = key_work[127:96];
    wire [31:0] w1 = key_work[95:64];
    wire [31:0] w2 = key_work[63:32];
    wire [31:0] w3 = key_work[31:0];
    wire [31:0] w3_back = w3 ^ w2;
    wire [31:0] sub_src = run_dec ? w3_back : w3;
    wire [31:0] rot_word = {sub_src[23:0], sub_src[31:24]};
    wire [31:0] sub_word;
    wire [3:0]  rcon_idx = run_dec ? (`AES_RCON_BASE - rnd) : rnd;
    wire [31:0] key_mix  = sub_word ^ {rcon(rcon_idx), 24'h000000};

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_key_sbox
            aes_sbox u_key_sbox (
                .din     (rot_word[31-8*g -: 8]),
                .inverse (1'b0),
                .dout    (sub_word[31-8*g -: 8])
            );
        end
    endgenerate

    wire [31:0] f0 = w0 ^ key_mix;
    wire [31:0] f1 = w1 ^ f0;
    wire [31:0] f2 = w2 ^ f1;
    wire [31:0] f3 = w3 ^ f2;
    wire [127:0] key_next = run_dec ? {w0 ^ key_mix, w1 ^ w0, w2 ^ w1, w3_back}
                                    : {f0, f1, f2, f3};

    // One round per clock; ten rounds keep a block far inside the run limit
    wire         last_round = (rnd == `AES_ROUND_LAST);
    wire [127:0] round_out;

    aes_round u_round (
        .state_in   (data_page),
        .round_key  (key_next),
        .decrypt    (run_dec),
        .last_round (last_round),
        .state_out  (round_out)
    );

    always @(posedge ref_clk) begin
        // Sleep wipes everything, the retained key included
        if (reset || radio_sleep) begin                                       // R19
            mode              <= `AES_MODE_RST;
            dir               <= `AES_DIR_ENC;
            run_dec           <= 1'b0;
            rnd               <= `AES_ROUND_FIRST;
            data_page         <= `AES_BLOCK_RST;
            key_work          <= `AES_BLOCK_RST;
            key_init          <= `AES_BLOCK_RST;
            chain             <= `AES_BLOCK_RST;
            read_mask         <= `AES_MASK_RST;
            sram_rdata        <= `AES_BYTE_RST;
            sram_rvalid       <= 1'b0;
            engine_busy       <= 1'b0;
            cipher_done_flag  <= 1'b0;
            cipher_error_flag <= 1'b0;
        end else if (clk_en) begin
            sram_rvalid <= host_acc;
            // Old byte goes out on every access, writes included
            if (host_acc)
                sram_rdata <= rd_byte;                                        // R13 R16 R25

            // Round stepping, which pauses while the radio is off with the clock divider at 0
            if (engine_busy && engine_ok) begin                               // R20
                data_page <= round_out;                                       // R12
                key_work  <= key_next;                                        // R4
                rnd       <= rnd + 4'h1;
                if (last_round) begin
                    engine_busy      <= 1'b0;
                    cipher_done_flag <= 1'b1;                                 // R22
                    chain            <= round_out;                            // R9
                end
            end

            // Window writes land on the page picked by the current mode
            if (win_wr) begin
                if (key_page) begin
                    key_init <= put_byte(key_init, win_idx, sram_wdata);      // R5
                    key_work <= put_byte(key_work, win_idx, sram_wdata);      // R3
                end else begin
                    data_page <= put_byte(data_page, win_idx, sram_wdata);    // R15
                end
            end

            // Control and alias share one set of fields
            if (ctrl_wr && !engine_busy) begin
                mode <= new_mode;                                             // R21
                dir  <= new_dir;                                              // R6
            end

            // Each run begins from the untouched loaded key
            if (start) begin
                run_dec           <= new_dir && (new_mode == `AES_MODE_ECB);  // R6
                data_page         <= run_input ^ key_init;                    // R5
                key_work          <= key_init;
                rnd               <= `AES_ROUND_FIRST;
                engine_busy       <= 1'b1;
                cipher_done_flag  <= 1'b0;                                    // R22
                cipher_error_flag <= 1'b0;
            end

            // Touching control mid-run kills the run and flags it
            if (abort) begin
                engine_busy       <= 1'b0;                                    // R23
                cipher_done_flag  <= 1'b0;                                    // R22
                cipher_error_flag <= 1'b1;                                    // R24
            end

            // A transfer that took only part of the result is an error
            if (sram_end && engine_ok) begin
                read_mask <= `AES_MASK_RST;
                if (short_read)
                    cipher_error_flag <= 1'b1;                                // R24
            end else begin
                read_mask <= mask_now;
            end
        end
    end
endmodule // aes_engine

`default_nettype wire

// file: bench/aes_engine_checker.sv
// Concurrent checks on the AES engine host port and run status
`default_nettype none
`include "aes_engine_regs.vh"

module aes_engine_checker (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       clk_en,
    // Transceiver state
    input wire logic       radio_sleep,
    input wire logic       radio_off_state,
    input wire logic [2:0] master_clock_divider_select,
    // Host byte access
    input wire logic       sram_valid,
    input wire logic       sram_write,
    input wire logic [7:0] sram_addr,
    input wire logic [7:0] sram_wdata,
    input wire logic       sram_end,
    // Engine outputs
    input wire logic [7:0] sram_rdata,
    input wire logic       sram_rvalid,
    input wire logic       engine_busy,
    input wire logic       cipher_done_flag,
    input wire logic       cipher_error_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    wire acc = sram_valid && clk_en && !radio_sleep
        && !(radio_off_state && master_clock_divider_select == `AES_CLKDIV_OFF);
    // Idle alias writes with the request bit and a runnable mode start a run; control writes at 0x83 are not modelled here
    wire start = acc && sram_write && sram_addr == `AES_ADDR_ALIAS && sram_wdata[7]
        && !engine_busy && (sram_wdata[6:4] == `AES_MODE_ECB || sram_wdata[6:4] == `AES_MODE_CBC);

    rvalid_follow_a: assert property (acc |=> sram_rvalid)
        else $error("accepted byte gave no read-back");
    rvalid_quiet_a: assert property (clk_en && !acc |=> !sram_rvalid)
        else $error("read-back without an accepted byte");
    start_busy_a: assert property (start |=> engine_busy && !cipher_done_flag)
        else $error("start request did not begin a run");
    run_len_a: assert property ($fell(engine_busy) && !cipher_error_flag
        |-> $past(engine_busy, 10) && !$past(engine_busy, 11) && cipher_done_flag)
        else $error("run length or done flag wrong");
    run_bound_a: assert property (engine_busy |-> ##[1:960] !engine_busy)
        else $error("run exceeded time limit");
    abort_run_a: assert property (engine_busy && acc && sram_addr == `AES_ADDR_CTRL
        |=> !engine_busy && cipher_error_flag && !cipher_done_flag)
        else $error("control access did not abort run");
    range_zero_a: assert property (acc && (sram_addr < `AES_ADDR_STATUS
        || sram_addr > `AES_ADDR_ALIAS) |=> sram_rdata == 8'h00)
        else $error("outside window returned data");
    sleep_clear_a: assert property (radio_sleep
        |=> !engine_busy && !cipher_done_flag && !cipher_error_flag)
        else $error("sleep left engine state");
    busy_done_a: assert property (engine_busy |-> !cipher_done_flag)
        else $error("done flag high while running");

    cover property (start);
    cover property (engine_busy && acc && sram_addr == `AES_ADDR_CTRL);
    cover property (acc && sram_addr == `AES_ADDR_CTRL && sram_wdata[6:4] == `AES_MODE_KEY);
    cover property (radio_sleep && sram_valid);
endmodule // aes_engine_checker

bind aes_engine aes_engine_checker aes_engine_checker_i (.ref_clk(ref_clk), .reset(reset),
    .clk_en(clk_en), .radio_sleep(radio_sleep), .radio_off_state(radio_off_state),
    .master_clock_divider_select(master_clock_divider_select), .sram_valid(sram_valid),
    .sram_write(sram_write), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
    .sram_end(sram_end), .sram_rdata(sram_rdata), .sram_rvalid(sram_rvalid),
    .engine_busy(engine_busy), .cipher_done_flag(cipher_done_flag),
    .cipher_error_flag(cipher_error_flag));
`default_nettype wire

// file: bench/aes_host_model.sv
// Host model issuing SRAM byte transfers to the AES engine
`default_nettype none
`include "aes_engine_regs.vh"

module aes_host_model (
    // Clock
    input  wire logic       ref_clk,
    // Byte access
    output var  logic       sram_valid,
    output var  logic       sram_write,
    output var  logic [7:0] sram_addr,
    output var  logic [7:0] sram_wdata,
    output var  logic       sram_end,
    // Returned bytes
    input  wire logic [7:0] sram_rdata,
    input  wire logic       sram_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sram_valid = 1'b0;
        sram_write = 1'b0;
        sram_addr  = 8'h00;
        sram_wdata = 8'h00;
        sram_end   = 1'b0;
    end

    // Bytes left-aligned in d and q; x marks a byte that never came back
    task automatic xfer(input logic wr, input logic [7:0] a, input int n,
                        input logic [151:0] d, output logic [151:0] q);
        q = '0;
        for (int k = 0; k <= n; k++) begin
            @(negedge ref_clk);
            if (k > 0) q[159-8*k -: 8] = sram_rvalid ? sram_rdata : 8'hxx;
            sram_valid = (k < n);
            sram_write = wr;
            sram_end   = (k == n - 1);
            if (k < n) begin
                sram_addr  = a + k[7:0];
                sram_wdata = d[151-8*k -: 8];
            end else begin
                // Released lines toggle so stale values cannot pass
                sram_addr  = ~sram_addr;
                sram_wdata = ~sram_wdata;
            end
        end
    endtask

    task automatic key_load(input logic [127:0] key);
        logic [151:0] q;
        xfer(1'b1, `AES_ADDR_CTRL, 17, {8'h10, key, 16'h0}, q);
    endtask

    task automatic run_block(input logic [7:0] ctrl, input logic [127:0] blk);
        logic [151:0] q;
        xfer(1'b1, `AES_ADDR_CTRL, 18, {ctrl, blk, ctrl | 8'h80, 8'h00}, q);
    endtask
endmodule // aes_host_model
`default_nettype wire

// file: bench/tb_top.sv
// Testbench for the AES engine: key load, code book, chaining, abort and sleep
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
    localparam logic [127:0] PT  = 128'h00112233445566778899aabbccddeeff;
    localparam logic [127:0] CT  = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
    localparam logic [127:0] K10 = 128'h13111d7fe3944a17f307a78b4d2b30c5;
    localparam logic [127:0] CZ  = 128'h66e94bd4ef8a2c3b884cfa59ca342b2e;
    logic         ref_clk;
    logic         reset;
    logic         clk_en;
    logic         radio_sleep;
    logic         radio_off_state;
    logic [2:0]   master_clock_divider_select;
    logic         sram_valid;
    logic         sram_write;
    logic [7:0]   sram_addr;
    logic [7:0]   sram_wdata;
    logic         sram_end;
    logic [7:0]   sram_rdata;
    logic         sram_rvalid;
    logic         engine_busy;
    logic         cipher_done_flag;
    logic         cipher_error_flag;
    logic [151:0] q;
    int           failures;
    int           check_count;

    aes_engine aes_engine_i (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .radio_sleep(radio_sleep), .radio_off_state(radio_off_state),
        .master_clock_divider_select(master_clock_divider_select), .sram_valid(sram_valid),
        .sram_write(sram_write), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
        .sram_end(sram_end), .sram_rdata(sram_rdata), .sram_rvalid(sram_rvalid),
        .engine_busy(engine_busy), .cipher_done_flag(cipher_done_flag),
        .cipher_error_flag(cipher_error_flag));
    aes_host_model aes_host_model_i (.ref_clk(ref_clk), .sram_valid(sram_valid),
        .sram_write(sram_write), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
        .sram_end(sram_end), .sram_rdata(sram_rdata), .sram_rvalid(sram_rvalid));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [151:0] seen, input logic [151:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic rd(input logic [7:0] a, input int n);
        aes_host_model_i.xfer(1'b0, a, n, '0, q);
    endtask

    // Start a run, then count cycles until done
    task automatic go(input logic [7:0] ctrl, input logic [127:0] blk);
        int c;
        c = 0;
        aes_host_model_i.run_block(ctrl, blk);
        chk(152'({engine_busy, cipher_done_flag}), 152'h2);
        while (cipher_done_flag !== 1'b1 && c < 960) begin
            @(negedge ref_clk);
            c++;
        end
        chk(152'(c), 152'd10);
    endtask

    initial begin
        #(40000 * 25);
        failures++;
        end_sim();
    end

    initial begin
        failures = 0;
        check_count = 0;
        reset = 1'b1;
        clk_en = 1'b1;
        radio_sleep = 1'b0;
        radio_off_state = 1'b0;
        master_clock_divider_select = 3'h0;
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        rd(8'h82, 2);
        chk(q, 152'h0);
        aes_host_model_i.key_load(KEY);
        rd(8'h83, 1);
        chk(q, {8'h10, 144'h0});
        $display("test key_load done");
        go(8'h00, PT);
        rd(8'h82, 1);
        chk(q, {8'h01, 144'h0});
        aes_host_model_i.xfer(1'b1, 8'h84, 16, {PT, 24'h0}, q);
        chk(q, {CT, 24'h0});
        rd(8'h84, 16);
        chk(q, {PT, 24'h0});
        aes_host_model_i.xfer(1'b1, 8'h83, 1, {8'h10, 144'h0}, q);
        rd(8'h84, 16);
        chk(q, {K10, 24'h0});
        go(8'h00, PT);
        rd(8'h84, 16);
        chk(q, {CT, 24'h0});
        $display("test code book done");
        // Chain on the block above, which ran in code book mode
        go(8'h20, CT ^ PT);
        rd(8'h84, 16);
        chk(q, {CT, 24'h0});
        aes_host_model_i.key_load(K10);
        go(8'h08, CT);
        rd(8'h84, 16);
        chk(q, {PT, 24'h0});
        $display("test chain and decrypt done");
        aes_host_model_i.run_block(8'h00, PT);
        rd(8'h83, 1);
        rd(8'h82, 1);
        chk(q, {8'h80, 144'h0});
        go(8'h00, PT);
        rd(8'h84, 4);
        rd(8'h82, 1);
        chk(q, {8'h81, 144'h0});
        $display("test abort done");
        rd(8'h80, 1);
        chk(q, 152'h0);
        rd(8'h95, 1);
        chk(q, 152'h0);
        aes_host_model_i.xfer(1'b1, 8'h82, 1, {8'hff, 144'h0}, q);
        rd(8'h82, 1);
        chk(q, {8'h81, 144'h0});
        @(negedge ref_clk);
        clk_en = 1'b0;
        rd(8'h82, 1);
        chk(q, {8'hxx, 144'h0});
        clk_en = 1'b1;
        radio_off_state = 1'b1;
        rd(8'h82, 1);
        chk(q, {8'hxx, 144'h0});
        master_clock_divider_select = 3'h1;
        rd(8'h82, 1);
        chk(q, {8'h81, 144'h0});
        $display("test refusals done");
        radio_sleep = 1'b1;
        rd(8'h82, 1);
        chk(q, {8'hxx, 144'h0});
        radio_sleep = 1'b0;
        rd(8'h82, 2);
        chk(q, 152'h0);
        rd(8'h84, 16);
        chk(q, 152'h0);
        go(8'h00, 128'h0);
        rd(8'h84, 16);
        chk(q, {CZ, 24'h0});
        aes_host_model_i.xfer(1'b1, 8'h94, 1, {8'hb0, 144'h0}, q);
        chk(152'(engine_busy), 152'h0);
        $display("test sleep done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
